// >>> rtl/dioc_controller.sv
`default_nettype none
module dioc_controller
(
    // Clock, reset, initialize
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_init,
    // Device address jumpers, caught while reset is held
    input wire logic i_addr_jumper_fit,
    input wire logic [7:0] i_addr_jumper,
    // Processor byte bus
    input wire logic [7:0] i_bus_dev_addr,
    input wire logic [dioc_pkg::DATA_W-1:0] i_bus_wdata,
    input wire logic i_cmd_strobe,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    input wire logic i_status_strobe,
    input wire logic i_ack_strobe,
    input wire logic i_proc_stat_req,
    output logic [dioc_pkg::DATA_W-1:0] o_bus_rdata,
    output logic o_bus_rvalid,
    output logic o_irq,
    // I/O module side
    input wire logic [dioc_pkg::MOD_CNT-1:0] i_mod_present,
    input wire logic [dioc_pkg::MOD_CNT-1:0] i_ext_irq_n,
    input wire logic [dioc_pkg::DATA_W-1:0] i_in_data,
    output logic [3:0] o_mod_sel,
    output logic [3:0] o_grp_sel,
    output logic [dioc_pkg::DATA_W-1:0] o_out_data,
    output logic o_out_strobe,
    output logic [dioc_pkg::DATA_W-1:0] o_sel_pattern,
    output logic o_pulse_run
);
    import dioc_pkg::*;

    typedef struct packed {
        logic [7:0] dev_addr;
        logic [8:0] jmp_m;
        logic [8:0] jmp_s;
        logic [MOD_CNT-1:0] present_m;
        logic [MOD_CNT-1:0] present;
        logic [MOD_CNT-1:0] ext_m;
        logic [MOD_CNT-1:0] ext_s;
        logic [DATA_W-1:0] in_m;
        logic [DATA_W-1:0] in_s;
        dioc_state_e state;
        logic [1:0] settle;
        logic expect_addr;
        logic seq_mode;
        logic write_mode;
        logic [SEL_W-1:0] sel;
        logic [DATA_W-1:0] rd_hold;
        logic busy;
        logic ext_flag;
        logic unavail;
        logic armed;
        logic enabled;
        logic queue;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic irq;
        logic [DATA_W-1:0] out_data;
        logic out_strobe;
        logic pulse_run;
    } dioc_ctl_s;

    dioc_ctl_s st_q;
    dioc_ctl_s st_d;
    logic [DATA_W-1:0] mem_rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [SEL_W-1:0] sel_from_byte(input logic [DATA_W-1:0] b);
        return {b[ADDR_MOD_HI:ADDR_MOD_LO], b[ADDR_GRP_HI:ADDR_GRP_LO]};
    endfunction

    function automatic logic mod_is_present(input logic [SEL_W-1:0] s,
                                            input logic [MOD_CNT-1:0] p);
        return p[s[ADDR_MOD_HI:ADDR_MOD_LO]];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    logic hit;
    logic cmd_go;
    logic wr_go;
    logic rd_go;
    logic stat_go;
    logic [DATA_W-1:0] status;
    logic [1:0] irq_ctl;
    logic addr_take;
    logic data_wr;
    logic ext_event;
    logic busy_fall;
    logic mem_we;
    logic [SEL_W-1:0] sel_next;

    always_comb
    begin
        st_d = st_q;
        hit = (i_bus_dev_addr == st_q.dev_addr);
        cmd_go = hit && i_cmd_strobe;
        wr_go = hit && i_wr_strobe;
        rd_go = hit && i_rd_strobe;
        stat_go = hit && (i_status_strobe || i_ack_strobe || i_proc_stat_req);
        irq_ctl = {i_bus_wdata[dioc_pos(CMD_IRQ_B0)], i_bus_wdata[dioc_pos(CMD_IRQ_B1)]};
        addr_take = wr_go && st_q.expect_addr;
        data_wr = wr_go && !st_q.expect_addr && st_q.write_mode && !st_q.busy;
        mem_we = data_wr;
        // Sequential mode steps the joint module/group code after each byte
        sel_next = st_q.seq_mode ? st_q.sel + 8'h01 : st_q.sel;

        // Pin synchronisers; only the second stage is read
        st_d.present_m = i_mod_present;
        st_d.present = st_q.present_m;
        st_d.ext_m = ~i_ext_irq_n;
        st_d.ext_s = st_q.ext_m;
        st_d.in_m = i_in_data;
        st_d.in_s = st_q.in_m;
        ext_event = |st_q.ext_s;

        // Status byte, unused positions stay zero
        status = 8'h00;
        status[dioc_pos(ST_EXT_IRQ)] = st_q.ext_flag;
        status[dioc_pos(ST_BUSY)] = st_q.busy;
        status[dioc_pos(ST_EXAMINE)] = st_q.ext_flag;
        status[dioc_pos(ST_UNAVAIL)] = st_q.unavail;

        st_d.rvalid = 1'b0;
        st_d.out_strobe = 1'b0;
        if (stat_go)
        begin
            st_d.rdata = status;
            st_d.rvalid = 1'b1;
        end

        // Command byte
        if (cmd_go)
        begin
            st_d.expect_addr = 1'b1;
            if (i_bus_wdata[dioc_pos(CMD_RANDOM_MODE_BIT)])
            begin
                st_d.seq_mode = 1'b0;
            end
            else if (i_bus_wdata[dioc_pos(CMD_SEQ)])
            begin
                st_d.seq_mode = 1'b1;
            end
            if (i_bus_wdata[dioc_pos(CMD_WRT)])
            begin
                st_d.write_mode = 1'b1;
            end
            else if (i_bus_wdata[dioc_pos(CMD_READ)])
            begin
                st_d.write_mode = 1'b0;
            end
            unique case (irq_ctl)
                2'b01:
                begin
                    st_d.armed = 1'b1;
                    st_d.enabled = 1'b1;
                end
                2'b10:
                begin
                    st_d.armed = 1'b1;
                    st_d.enabled = 1'b0;
                end
                2'b11:
                begin
                    st_d.armed = 1'b0;
                    st_d.enabled = 1'b0;
                end
                2'b00:
                begin
                    st_d.armed = st_q.armed;
                end
            endcase
            // Mode change restarts the transfer handshake
            st_d.state = DIOC_READY;
            st_d.busy = 1'b1;
        end

        // Transfer engine
        unique case (st_q.state)
            DIOC_READY:
            begin
                if (addr_take)
                begin
                    st_d.sel = sel_from_byte(i_bus_wdata);
                    st_d.expect_addr = 1'b0;
                    st_d.unavail = !mod_is_present(sel_from_byte(i_bus_wdata),
                                                   st_q.present);
                    st_d.pulse_run = (sel_from_byte(i_bus_wdata) == PULSE_SLOT);
                    st_d.busy = 1'b1;
                    st_d.settle = RD_SETTLE_CYC;
                    st_d.state = st_q.write_mode ? DIOC_WR_WAIT : DIOC_RD_WAIT;
                end
                else if (data_wr)
                begin
                    st_d.out_data = i_bus_wdata;
                    st_d.out_strobe = 1'b1;
                    st_d.sel = sel_next;
                    st_d.busy = 1'b1;
                    st_d.state = DIOC_WR_WAIT;
                end
                else if (rd_go && !st_q.write_mode && !st_q.busy && !st_q.expect_addr)
                begin
                    st_d.rdata = st_q.rd_hold;
                    st_d.rvalid = 1'b1;
                    st_d.sel = sel_next;
                    st_d.busy = 1'b1;
                    st_d.settle = RD_SETTLE_CYC;
                    st_d.state = DIOC_RD_WAIT;
                end
            end
            DIOC_RD_WAIT:
            begin
                // Selection has reached the pins; wait for synchroniser
                if (st_q.settle == 2'h0)
                begin
                    st_d.rd_hold = st_q.in_s;
                    st_d.busy = 1'b0;
                    st_d.state = DIOC_READY;
                end
                else
                begin
                    st_d.settle = st_q.settle - 2'h1;
                end
            end
            DIOC_WR_WAIT:
            begin
                st_d.busy = 1'b0;
                st_d.state = DIOC_READY;
            end
        endcase
        if (cmd_go)
        begin
            // A wait ending in the same cycle must not clear busy
            st_d.state = DIOC_READY;
            st_d.busy = 1'b1;
        end

        // Interrupt queue; an event wins over the acknowledge
        busy_fall = st_q.busy && !st_d.busy;
        if (i_ack_strobe && hit)
        begin
            st_d.queue = 1'b0;
            st_d.ext_flag = 1'b0;
        end
        if (ext_event)
        begin
            st_d.ext_flag = 1'b1;
        end
        if (st_q.armed && (busy_fall || ext_event))
        begin
            st_d.queue = 1'b1;
        end
        if (!st_d.armed)
        begin
            st_d.queue = 1'b0;
        end
        st_d.irq = st_d.queue && st_d.enabled;

        if (i_rst || i_init)
        begin
            st_d = '0;
            st_d.state = DIOC_READY;
            st_d.seq_mode = 1'b0;
            st_d.write_mode = 1'b0;
            st_d.sel = RESET_SEL;
            st_d.dev_addr = st_q.dev_addr;
        end
        // Straps pass two stages, so reset must outlast them
        st_d.jmp_m = {i_addr_jumper_fit, i_addr_jumper};
        st_d.jmp_s = st_q.jmp_m;
        if (i_rst)
        begin
            st_d.dev_addr = st_q.jmp_s[8] ? st_q.jmp_s[7:0] : DEV_ADDR_DEFAULT;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        st_q <= st_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output group pattern store

    dioc_group_mem u_group_mem
    (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_we(mem_we),
        .i_waddr(st_q.sel),
        .i_wdata(i_bus_wdata),
        .i_raddr(st_q.sel),
        .o_rdata(mem_rdata)
    );

    assign o_bus_rdata = st_q.rdata;
    assign o_bus_rvalid = st_q.rvalid;
    assign o_irq = st_q.irq;
    assign o_mod_sel = st_q.sel[ADDR_MOD_HI:ADDR_MOD_LO];
    assign o_grp_sel = st_q.sel[ADDR_GRP_HI:ADDR_GRP_LO];
    assign o_out_data = st_q.out_data;
    assign o_out_strobe = st_q.out_strobe;
    assign o_sel_pattern = mem_rdata;
    assign o_pulse_run = st_q.pulse_run;
endmodule
`default_nettype wire

// >>> rtl/dioc_pkg.sv
`default_nettype none
package dioc_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned SEL_W = 8;
    localparam int unsigned MOD_CNT = 16;
    // Device address when no jumper is fitted
    localparam logic [7:0] DEV_ADDR_DEFAULT = 8'h4b;
    // Bus bit positions; the documented bit 0 is the MSB of the byte
    localparam int unsigned DOC_MSB = 7;
    localparam int unsigned CMD_IRQ_B0 = 0;
    localparam int unsigned CMD_IRQ_B1 = 1;
    localparam int unsigned CMD_RANDOM_MODE_BIT = 4;
    localparam int unsigned CMD_SEQ = 5;
    localparam int unsigned CMD_WRT = 6;
    localparam int unsigned CMD_READ = 7;
    localparam int unsigned ST_EXT_IRQ = 3;
    localparam int unsigned ST_BUSY = 4;
    localparam int unsigned ST_EXAMINE = 5;
    localparam int unsigned ST_UNAVAIL = 7;
    // Address field split
    localparam int unsigned ADDR_MOD_HI = 7;
    localparam int unsigned ADDR_MOD_LO = 4;
    localparam int unsigned ADDR_GRP_HI = 3;
    localparam int unsigned ADDR_GRP_LO = 0;
    // Pulse generator slot: module, group in one selection code
    localparam logic [7:0] PULSE_SLOT = 8'hf0;
    // Input byte settles through the pin synchroniser before it is held
    localparam logic [1:0] RD_SETTLE_CYC = 2'h3;
    localparam logic [7:0] RESET_SEL = 8'h00;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    typedef enum logic [1:0] {
        DIOC_READY,
        DIOC_RD_WAIT,
        DIOC_WR_WAIT
    } dioc_state_e;
    function automatic int unsigned dioc_pos(input int unsigned doc_bit);
        return DOC_MSB - doc_bit;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/dioc_group_mem.sv
`default_nettype none
module dioc_group_mem
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Write port
    input wire logic i_we,
    input wire logic [dioc_pkg::SEL_W-1:0] i_waddr,
    input wire logic [dioc_pkg::DATA_W-1:0] i_wdata,
    // Read port, data registered
    input wire logic [dioc_pkg::SEL_W-1:0] i_raddr,
    output logic [dioc_pkg::DATA_W-1:0] o_rdata
);
    import dioc_pkg::*;

    typedef struct packed {
        logic [DATA_W-1:0] rdata;
    } dioc_mem_s;

    // Storage stays outside the struct so it can map onto a RAM
    logic [DATA_W-1:0] mem_q [0:(1<<SEL_W)-1];
    dioc_mem_s st_q;
    dioc_mem_s st_d;

    always_comb
    begin
        st_d = st_q;
        st_d.rdata = (i_we && i_waddr == i_raddr) ? i_wdata : mem_q[i_raddr];
        if (i_rst)
        begin
            st_d.rdata = RESET_BYTE;
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        st_q <= st_d;
        if (i_we)
        begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    assign o_rdata = st_q.rdata;
endmodule
`default_nettype wire

// >>> tb/dioc_checker.sv
`default_nettype none
module dioc_checker
    import dioc_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_init,
    // Processor bus
    input wire logic [7:0] i_bus_dev_addr,
    input wire logic [DATA_W-1:0] i_bus_wdata,
    input wire logic i_cmd_strobe,
    input wire logic i_wr_strobe,
    input wire logic i_rd_strobe,
    input wire logic i_status_strobe,
    input wire logic i_ack_strobe,
    input wire logic i_proc_stat_req,
    input wire logic [DATA_W-1:0] o_bus_rdata,
    input wire logic o_bus_rvalid,
    input wire logic o_irq,
    // Module side
    input wire logic [3:0] o_mod_sel,
    input wire logic [3:0] o_grp_sel,
    input wire logic [DATA_W-1:0] o_out_data,
    input wire logic o_out_strobe,
    input wire logic o_pulse_run
);
    logic hit, sreq;
    ////////////////////////////////////////
    // Strap not modelled: only valid while the default address is kept
    assign hit = i_bus_dev_addr == DEV_ADDR_DEFAULT;
    assign sreq = hit && (i_status_strobe || i_ack_strobe || i_proc_stat_req);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);
    sequence st_ans;
        o_bus_rvalid && $past(sreq);
    endsequence
    status_answer_a: assert property (sreq |=> o_bus_rvalid)
        else $error("status request not answered");
    answer_cause_a: assert property (o_bus_rvalid |-> $past(sreq || hit && i_rd_strobe))
        else $error("answer without request");
    zero_bits_a: assert property (st_ans |-> (o_bus_rdata & 8'he2) == 8'h00)
        else $error("reserved status bit set");
    examine_copy_a: assert property (st_ans |-> o_bus_rdata[2] == o_bus_rdata[4])
        else $error("examine differs from external flag");
    out_byte_a: assert property (o_out_strobe |->
        $past(hit && i_wr_strobe) && o_out_data == $past(i_bus_wdata))
        else $error("output byte not from a write");
    disarm_quiet_a: assert property (hit && i_cmd_strobe && i_bus_wdata[7:6] == 2'b11
        |-> ##2 !o_irq) else $error("irq after disarm");
    pulse_slot_a: assert property ($rose(o_pulse_run) |->
        {o_mod_sel, o_grp_sel} == PULSE_SLOT) else $error("pulse on wrong slot");
    init_clear_a: assert property (i_init |=> !o_irq && !o_pulse_run)
        else $error("init left state");
    cover property (o_out_strobe);
    cover property (o_irq);
    cover property (o_pulse_run);
endmodule
`default_nettype wire

// >>> tb/dioc_io_model.sv
`default_nettype none
module dioc_io_model
(
    // Clock and selection
    input wire logic i_sys_clk,
    input wire logic [7:0] i_sel,
    // Bench controls
    input wire logic [15:0] i_fitted,
    input wire logic i_ground,
    // Module pins
    output logic [15:0] o_present,
    output logic [15:0] o_ext_irq_n,
    output logic [7:0] o_in_data
);
    logic [7:0] spin_q = 8'h00;
    ////////////////////////////////////////
    always_ff @(posedge i_sys_clk)
        spin_q <= spin_q + 8'h01;
    assign o_present = i_fitted;
    // Pulled-up lines; module 5 grounds its own on request
    assign o_ext_irq_n = i_ground ? 16'hffdf : 16'hffff;
    // Nobody drives the bus for an absent module, so it wanders
    assign o_in_data = i_fitted[i_sel[7:4]] ? i_sel ^ 8'h5a : spin_q;
endmodule
`default_nettype wire

// >>> tb/tb_digital_io_group_controller.sv
`default_nettype none
module tb_digital_io_group_controller;
    timeunit 1ns;
    timeprecision 1ns;
    import dioc_pkg::*;
    logic i_sys_clk = 1'b0, i_rst = 1'b1, i_init = 1'b0, i_addr_jumper_fit = 1'b0;
    logic i_cmd_strobe, i_wr_strobe, i_rd_strobe, i_status_strobe, i_ack_strobe;
    logic i_proc_stat_req, o_bus_rvalid, o_irq, o_out_strobe, o_pulse_run, ground = 1'b0;
    logic [7:0] i_addr_jumper = 8'h00, i_bus_dev_addr = 8'h4b, i_bus_wdata = 8'h00;
    logic [7:0] i_in_data, o_bus_rdata, o_out_data, o_sel_pattern, s;
    logic [15:0] i_mod_present, i_ext_irq_n, fitted;
    logic [5:0] stb = 6'h00;
    logic [3:0] o_mod_sel, o_grp_sel;
    logic [7:0] exp_pat [256];
    logic [7:0] aq [$];
    int fails = 0, check_count = 0;
    ////////////////////////////////////////
    assign {i_proc_stat_req, i_ack_strobe, i_status_strobe, i_rd_strobe} = stb[5:2];
    assign {i_wr_strobe, i_cmd_strobe} = stb[1:0];
    initial
        forever #25 i_sys_clk = ~i_sys_clk;
    dioc_controller u_dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_init(i_init),
        .i_addr_jumper_fit(i_addr_jumper_fit), .i_addr_jumper(i_addr_jumper),
        .i_bus_dev_addr(i_bus_dev_addr), .i_bus_wdata(i_bus_wdata),
        .i_cmd_strobe(i_cmd_strobe), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
        .i_status_strobe(i_status_strobe), .i_ack_strobe(i_ack_strobe),
        .i_proc_stat_req(i_proc_stat_req), .o_bus_rdata(o_bus_rdata),
        .o_bus_rvalid(o_bus_rvalid), .o_irq(o_irq), .i_mod_present(i_mod_present),
        .i_ext_irq_n(i_ext_irq_n), .i_in_data(i_in_data), .o_mod_sel(o_mod_sel),
        .o_grp_sel(o_grp_sel), .o_out_data(o_out_data), .o_out_strobe(o_out_strobe),
        .o_sel_pattern(o_sel_pattern), .o_pulse_run(o_pulse_run)
    );
    dioc_io_model u_io (
        .i_sys_clk(i_sys_clk), .i_sel({o_mod_sel, o_grp_sel}), .i_fitted(fitted),
        .i_ground(ground), .o_present(i_mod_present), .o_ext_irq_n(i_ext_irq_n),
        .o_in_data(i_in_data)
    );
    ////////////////////////////////////////
    function automatic logic [7:0] st(input logic ext, input logic busy, input logic gone);
        return {3'h0, ext, busy, ext, 1'b0, gone};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp)
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        fails += int'(got !== exp);
    endtask
    // Kinds: 0 cmd, 1 write, 2 read, 3 status, 4 ack, 5 processor request
    task automatic bus(input int k, input logic [7:0] d, input logic [7:0] da = 8'h4b);
        @(posedge i_sys_clk);
        stb <= 6'(1 << k);
        i_bus_wdata <= d;
        i_bus_dev_addr <= da;
        @(posedge i_sys_clk);
        stb <= 6'h00;
    endtask
    task automatic ask(input int k);
        bus(k, 8'h00);
        #1;
        chk({7'h00, o_bus_rvalid}, 8'h01);
        s = o_bus_rdata;
    endtask
    // Polls busy; a command without an address never clears it
    task automatic settle();
        repeat (40)
        begin
            ask(3);
            if (s[3] === 1'b0)
                return;
        end
        finish_test(1'b1);
    endtask
    task automatic irq_is(input logic v);
        repeat (6) @(posedge i_sys_clk);
        #1;
        chk({7'h00, o_irq}, {7'h00, v});
    endtask
    task automatic finish_test(input logic hung);
        fails += int'(hung);
        $display("checks %0d fails %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        logic [7:0] a, b, d;
        int i;
        void'($urandom(32'h457f0442));
        fitted = 16'($urandom) | 16'h0003;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        for (i = 3; i < 6; i++)
        begin
            ask(i);
            chk(s, 8'h00);
        end
        // Odd passes use sequential mode; pass 1 wraps past the top code
        for (i = 0; i < 8; i++)
        begin
            a = (i == 0) ? PULSE_SLOT : (i == 1) ? 8'hff : 8'($urandom);
            d = 8'($urandom);
            b = a + 8'h01;
            bus(0, i[0] ? 8'h06 : 8'h0a);
            bus(1, a);
            settle();
            chk({7'h00, o_pulse_run}, {7'h00, a == PULSE_SLOT});
            bus(1, d);
            settle();
            chk(o_out_data, d);
            bus(1, ~d);
            settle();
            exp_pat[a] = i[0] ? d : ~d;
            if (i[0])
                exp_pat[b] = ~d;
            chk({o_mod_sel, o_grp_sel}, i[0] ? b + 8'h01 : a);
            aq.push_back(a);
        end
        foreach (aq[j])
        begin
            bus(0, 8'h0a);
            bus(1, aq[j]);
            settle();
            bus(1, 8'h33, 8'h4c);
            repeat (3) @(posedge i_sys_clk);
            #1;
            chk(o_sel_pattern, exp_pat[aq[j]]);
        end
        for (i = 0; i < 16; i++)
        begin
            a = {i[3:0], 4'h3};
            bus(0, 8'h09);
            bus(1, a);
            settle();
            chk(s, st(1'b0, 1'b0, !fitted[i]));
            if (fitted[i])
            begin
                ask(2);
                chk(s, a ^ 8'h5a);
            end
        end
        bus(0, 8'h4a);
        bus(1, 8'h00);
        settle();
        irq_is(1'b1);
        bus(0, 8'h8a);
        irq_is(1'b0);
        bus(0, 8'h4a);
        irq_is(1'b1);
        bus(0, 8'h0a);
        irq_is(1'b1);
        bus(0, 8'hca);
        irq_is(1'b0);
        bus(0, 8'h4a);
        @(posedge i_sys_clk) ground <= 1'b1;
        irq_is(1'b1);
        ask(3);
        chk(s, st(1'b1, 1'b1, 1'b0));
        @(posedge i_sys_clk) ground <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        ask(4);
        ask(3);
        chk(s, st(1'b0, 1'b1, 1'b0));
        chk({7'h00, o_irq}, 8'h00);
        @(posedge i_sys_clk) i_init <= 1'b1;
        @(posedge i_sys_clk) i_init <= 1'b0;
        ask(3);
        chk(s, 8'h00);
        chk({7'h00, o_irq}, 8'h00);
        ask(2);
        chk(s, 8'h00);
        chk({o_mod_sel, o_grp_sel}, RESET_SEL);
        finish_test(1'b0);
    end
endmodule
bind dioc_controller dioc_checker u_chk (
    .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_init(i_init),
    .i_bus_dev_addr(i_bus_dev_addr), .i_bus_wdata(i_bus_wdata),
    .i_cmd_strobe(i_cmd_strobe), .i_wr_strobe(i_wr_strobe), .i_rd_strobe(i_rd_strobe),
    .i_status_strobe(i_status_strobe), .i_ack_strobe(i_ack_strobe),
    .i_proc_stat_req(i_proc_stat_req), .o_bus_rdata(o_bus_rdata),
    .o_bus_rvalid(o_bus_rvalid), .o_irq(o_irq), .o_mod_sel(o_mod_sel),
    .o_grp_sel(o_grp_sel), .o_out_data(o_out_data), .o_out_strobe(o_out_strobe),
    .o_pulse_run(o_pulse_run)
);
`default_nettype wire
